// ===== rtl/afd_pkg.sv
// constants and register layout of the front-end fault aggregator
package afd_pkg;
  localparam int REG_W    = 16;
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int IDX_W    = 6;
  localparam int OW_W     = 6;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DISABLE = 6'h06;
  localparam logic [IDX_W-1:0] IDX_DETAIL  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CTRL    = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CONV    = 6'h09;
  localparam logic [IDX_W-1:0] IDX_NONE    = 6'h3F;
  // summary status fields
  localparam int SUM_ANY  = 0;
  localparam int SUM_WARN = 2;
  localparam int SUM_SHDN = 3;
  // detail status and disable fields
  localparam int DET_ANY        = 0;
  localparam int DET_INPUT_OC   = 1;
  localparam int DET_FIELD_OC   = 2;
  localparam int DET_COMP       = 6;
  localparam int DET_EXC        = 7;
  localparam int DET_POS_OVER   = 8;
  localparam int DET_NEG_OVER   = 9;
  localparam int DET_POS_UNDER  = 10;
  localparam int DET_NEG_UNDER  = 11;
  localparam logic [REG_W-1:0] DIS_WR_MASK = 16'h0FC6;
  localparam logic [REG_W-1:0] DIS_RST     = 16'h0000;
  // control fields
  localparam int CTL_EXC_EN   = 0;
  localparam int CTL_COMP_EN  = 1;
  localparam int CTL_FOUR_W   = 2;
  localparam int CTL_FIELD_EN = 3;
  localparam int CTL_CUR_MODE = 4;
  localparam int CTL_OW_LO    = 5;
  localparam int CTL_FUNC_LO  = 12;
  localparam int CTL_FUNC_HI  = 13;
  localparam logic [REG_W-1:0] CTL_WR_MASK = 16'h37FF;
  localparam logic [REG_W-1:0] CTL_RST     = 16'h0000;
  // converter status fields
  localparam int CNV_READY   = 0;
  localparam int CNV_FAULT   = 1;
  localparam int CNV_STANDBY = 2;
  localparam logic CNV_STANDBY_RST = 1'b1;
  // fault pin function codes
  localparam logic [1:0] FUNC_SENSE = 2'h1;
  localparam logic [1:0] FUNC_DRIVE = 2'h2;
endpackage

// ===== rtl/afd_reg_if.sv
// register access carrier between bus slave and core
`timescale 1ns/1ps
interface afd_reg_if;
  import afd_pkg::*;
  logic             wr;
  logic             rd;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wdata;
  logic [1:0]       be;
  logic [REG_W-1:0] rdata;
  modport bus  (output wr, rd, idx, wdata, be, input rdata);
  modport core (input wr, rd, idx, wdata, be, output rdata);
endinterface

// ===== rtl/afd_flag_cell.sv
// latched flags, set by event, cleared on request, set wins
`timescale 1ns/1ps
module afd_flag_cell #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // events
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // state
  output wire logic [W-1:0] flag
);
  typedef struct packed {
    logic [W-1:0] flag;
  } afd_cell_state_t;

  afd_cell_state_t s;
  afd_cell_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.flag = set | (s.flag & ~clr);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign flag = s.flag;
endmodule // afd_flag_cell

// ===== rtl/afd_wb_slave.sv
// classic wishbone slave front end
`timescale 1ns/1ps
module afd_wb_slave (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  // wishbone
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [afd_pkg::WB_ADR_W-1:0]   adr_i,
  input  wire logic [afd_pkg::WB_SEL_W-1:0]   sel_i,
  input  wire logic [afd_pkg::WB_DAT_W-1:0]   dat_i,
  output wire logic [afd_pkg::WB_DAT_W-1:0]   dat_o,
  output wire logic                           ack_o,
  // register side
  afd_reg_if.bus                              rif
);
  import afd_pkg::*;

  typedef struct packed {
    logic                ack;
    logic [WB_DAT_W-1:0] dat;
  } afd_wb_state_t;

  afd_wb_state_t s;
  afd_wb_state_t next_s;
  logic          take;

  assign take = cyc_i & stb_i & ~s.ack;
  assign rif.wr = take & we_i;
  assign rif.rd = take & ~we_i;
  assign rif.wdata = dat_i[REG_W-1:0];
  assign rif.be = sel_i[1:0];
  assign rif.idx = (adr_i[1:0] == 2'h0) ? adr_i[WB_ADR_W-1:2] : IDX_NONE;

  always_comb
  begin
    next_s = s;
    next_s.ack = take;
    if (rif.rd)
      next_s.dat = {16'h0000, rif.rdata};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign ack_o = s.ack;
  assign dat_o = s.dat;
endmodule // afd_wb_slave

// ===== rtl/afd_top.sv
// front-end diagnostic fault aggregator, top level
// How it works
// - fault pin pulled low while any summary or detail error bit is set
// - pin function drive: converter also pulls pin low on its own error
// - pin function sense: pin level ORed with converter errors into flag
// - sensed pin level is a plain input, latched into converter fault flag with each result in sense mode
// - converter fault flag refreshed only when a result is written
// - overtemperature warning latched, cleared by reading summary register
// - shutdown forces voltage mode, sources and field off, latches flag
// - register bus keeps working during thermal shutdown
// - temperature back below threshold clears summary bit 0, restores functions
// - four over/under flags at detail bits 11 to 8 while condition lasts
// - any detail flag also sets summary bit 0
// - over/under flags enabled at reset, suppressed by disable bits
// - open-wire currents source or sink 1 or 100 uA, off at reset
// - excitation compliance flag set while excitation on and limit exceeded
// - compensation compliance flag set while compensation on and exceeded
// - four-wire mode switches off only the compensation current
// - ready flag high during calibration, cleared at end, then standby
`timescale 1ns/1ps
module afd_top (
  // clock and reset
  input  wire logic                          CLOCK,
  input  wire logic                          RST_B,
  // wishbone slave
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [afd_pkg::WB_ADR_W-1:0]  WB_ADR_I,
  input  wire logic [afd_pkg::WB_SEL_W-1:0]  WB_SEL_I,
  input  wire logic [afd_pkg::WB_DAT_W-1:0]  WB_DAT_I,
  output wire logic [afd_pkg::WB_DAT_W-1:0]  WB_DAT_O,
  output wire logic                          WB_ACK_O,
  // comparator levels
  input  wire logic                          OVERTEMP_IN,
  input  wire logic                          SHUTDOWN_TEMP_IN,
  input  wire logic                          POS_OVER_IN,
  input  wire logic                          NEG_OVER_IN,
  input  wire logic                          POS_UNDER_IN,
  input  wire logic                          NEG_UNDER_IN,
  input  wire logic                          FIELD_OC_IN,
  input  wire logic                          INPUT_OC_IN,
  input  wire logic                          EXC_COMPLY_IN,
  input  wire logic                          COMP_COMPLY_IN,
  // converter events
  input  wire logic                          CONV_DONE,
  input  wire logic                          CAL_START,
  input  wire logic                          CAL_END,
  input  wire logic                          ADC_INT_ERR,
  // shared open-drain fault pin
  input  wire logic                          FAULT_N_I,
  output wire logic                          FAULT_N_O,
  output wire logic                          FAULT_N_OE,
  // analog controls
  output wire logic                          EXC_EN,
  output wire logic                          COMP_EN,
  output wire logic                          FIELD_EN,
  output wire logic                          CURRENT_MODE,
  output wire logic                          PGA_SHDN,
  output wire logic [afd_pkg::OW_W-1:0]      OW_CTRL
);
  import afd_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] dis_mask;
    logic [REG_W-1:0] ctrl;
    logic [REG_W-1:0] detail;
    logic             ot_live;
    logic             sd_live;
    logic             conv_fault;
    logic             ready;
    logic             standby;
    logic             pin_lvl;
    logic             fault_oe;
    logic             exc_en;
    logic             comp_en;
    logic             field_en;
    logic             cur_mode;
    logic             pga_shdn;
    logic [OW_W-1:0]  ow;
  } afd_top_state_t;

  afd_top_state_t   s;
  afd_top_state_t   next_s;
  afd_reg_if        rif ();
  logic [1:0]       temp_flag;
  logic [REG_W-1:0] summary_val;
  logic [REG_W-1:0] conv_val;
  logic [REG_W-1:0] rdata;
  logic [1:0]       pin_func;
  logic             rd_summary;
  logic             afe_any;
  logic             func_sense;
  logic             func_drive;
  logic [REG_W-1:0] det_raw;

  function automatic logic [REG_W-1:0] lane_merge(
    input logic [REG_W-1:0] old_v,
    input logic [REG_W-1:0] new_v,
    input logic [1:0]       be,
    input logic [REG_W-1:0] wmask
  );
    logic [REG_W-1:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // bus slave keeps running in shutdown: no path gates it by temperature
  afd_wb_slave u_wb (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .cyc_i (WB_CYC_I),
    .stb_i (WB_STB_I),
    .we_i  (WB_WE_I),
    .adr_i (WB_ADR_I),
    .sel_i (WB_SEL_I),
    .dat_i (WB_DAT_I),
    .dat_o (WB_DAT_O),
    .ack_o (WB_ACK_O),
    .rif   (rif.bus)
  );

  // summary read strobe
  assign rd_summary = rif.rd & (rif.idx == IDX_SUMMARY);

  // latched temperature flags, read of summary clears them
  afd_flag_cell #(
    .W (2)
  ) u_temp (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .set   ({s.sd_live, s.ot_live}),
    .clr   ({2{rd_summary}}),
    .flag  (temp_flag)
  );

  // pin function decode
  assign pin_func = s.ctrl[CTL_FUNC_HI:CTL_FUNC_LO];
  assign func_sense = (pin_func == FUNC_SENSE);
  assign func_drive = (pin_func == FUNC_DRIVE);

  // summary register image
  always_comb
  begin
    summary_val = '0;
    summary_val[SUM_ANY] = (|s.detail) | s.ot_live | s.sd_live;
    summary_val[SUM_WARN] = temp_flag[0];
    summary_val[SUM_SHDN] = temp_flag[1];
  end

  // converter status image
  always_comb
  begin
    conv_val = '0;
    conv_val[CNV_READY] = s.ready;
    conv_val[CNV_FAULT] = s.conv_fault;
    conv_val[CNV_STANDBY] = s.standby;
  end

  // any front-end fault, summary or detail
  assign afe_any = (|summary_val) | (|s.detail);

  // read decode, unmapped indices read zero
  always_comb
  begin
    if (rif.idx == IDX_SUMMARY)
      rdata = summary_val;
    else if (rif.idx == IDX_DISABLE)
      rdata = s.dis_mask;
    else if (rif.idx == IDX_DETAIL)
      rdata = s.detail;
    else if (rif.idx == IDX_CTRL)
      rdata = s.ctrl;
    else if (rif.idx == IDX_CONV)
      rdata = conv_val;
    else
      rdata = '0;
  end

  assign rif.rdata = rdata;

  // raw detail conditions, before the disable mask
  always_comb
  begin
    det_raw = '0;
    det_raw[DET_POS_OVER] = POS_OVER_IN;
    det_raw[DET_NEG_OVER] = NEG_OVER_IN;
    det_raw[DET_POS_UNDER] = POS_UNDER_IN;
    det_raw[DET_NEG_UNDER] = NEG_UNDER_IN;
    det_raw[DET_FIELD_OC] = FIELD_OC_IN;
    det_raw[DET_INPUT_OC] = INPUT_OC_IN;
    det_raw[DET_EXC] = s.exc_en & EXC_COMPLY_IN;
    det_raw[DET_COMP] = s.comp_en & COMP_COMPLY_IN;
  end

  // next state
  always_comb
  begin
    next_s = s;
    next_s.ot_live = OVERTEMP_IN;
    next_s.sd_live = SHUTDOWN_TEMP_IN;
    next_s.pin_lvl = 1'b0;

    // register writes
    if (rif.wr)
    begin
      if (rif.idx == IDX_DISABLE)
      begin
        next_s.dis_mask = lane_merge(s.dis_mask, rif.wdata, rif.be,
                                     DIS_WR_MASK);
      end
      else if (rif.idx == IDX_CTRL)
      begin
        next_s.ctrl = lane_merge(s.ctrl, rif.wdata, rif.be, CTL_WR_MASK);
      end
    end

    // analog controls, shutdown overrides while it lasts
    next_s.exc_en = s.ctrl[CTL_EXC_EN] & ~SHUTDOWN_TEMP_IN;
    next_s.comp_en = s.ctrl[CTL_COMP_EN] & ~s.ctrl[CTL_FOUR_W]
                     & ~SHUTDOWN_TEMP_IN;
    next_s.field_en = s.ctrl[CTL_FIELD_EN] & ~SHUTDOWN_TEMP_IN;
    next_s.cur_mode = s.ctrl[CTL_CUR_MODE] & ~SHUTDOWN_TEMP_IN;
    next_s.pga_shdn = SHUTDOWN_TEMP_IN;
    if (SHUTDOWN_TEMP_IN)
      next_s.ow = '0;
    else
      next_s.ow = s.ctrl[CTL_OW_LO +: OW_W];

    // detail flags follow their conditions, masked by disable bits
    next_s.detail = det_raw & ~s.dis_mask;
    next_s.detail[DET_ANY] = |next_s.detail;

    // converter fault flag, refreshed only on a new result
    if (CONV_DONE)
    begin
      if (func_sense)
      begin
        next_s.conv_fault = ADC_INT_ERR | ~FAULT_N_I;
      end
      else
      begin
        next_s.conv_fault = ADC_INT_ERR;
      end
    end

    // calibration ready flag
    if (CAL_START)
    begin
      next_s.ready = 1'b1;
      next_s.standby = 1'b0;
    end
    else if (CAL_END)
    begin
      next_s.ready = 1'b0;
      next_s.standby = 1'b1;
    end

    // open-drain pin, front end always, converter only in drive mode
    next_s.fault_oe = afe_any
                      | (func_drive & s.conv_fault);
  end

  // state register, one reset value per field
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      s.dis_mask <= DIS_RST;
      s.ctrl <= CTL_RST;
      s.detail <= '0;
      s.ot_live <= 1'b0;
      s.sd_live <= 1'b0;
      s.conv_fault <= 1'b0;
      s.ready <= 1'b0;
      s.standby <= CNV_STANDBY_RST;
      s.pin_lvl <= 1'b0;
      s.fault_oe <= 1'b0;
      s.exc_en <= 1'b0;
      s.comp_en <= 1'b0;
      s.field_en <= 1'b0;
      s.cur_mode <= 1'b0;
      s.pga_shdn <= 1'b0;
      s.ow <= '0;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state flops
  assign FAULT_N_O = s.pin_lvl;
  assign FAULT_N_OE = s.fault_oe;
  assign EXC_EN = s.exc_en;
  assign COMP_EN = s.comp_en;
  assign FIELD_EN = s.field_en;
  assign CURRENT_MODE = s.cur_mode;
  assign PGA_SHDN = s.pga_shdn;
  assign OW_CTRL = s.ow;
endmodule // afd_top

// ===== test/afd_monitor.sv
// concurrent checks on the fault aggregator top-level ports
`timescale 1ns/1ps
module afd_monitor (
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_B,
  // bus
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  // comparators
  input wire logic       OVERTEMP_IN,
  input wire logic       SHUTDOWN_TEMP_IN,
  // pin and controls
  input wire logic       FAULT_N_O,
  input wire logic       FAULT_N_OE,
  input wire logic       EXC_EN,
  input wire logic       COMP_EN,
  input wire logic       FIELD_EN,
  input wire logic       CURRENT_MODE,
  input wire logic       PGA_SHDN,
  input wire logic [5:0] OW_CTRL
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  ack_latency_a: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (
    $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  drive_low_a: assert property (!FAULT_N_O)
    else $error("fault pin driven high");
  temp_pin_a: assert property (
    (OVERTEMP_IN || SHUTDOWN_TEMP_IN) [*4] |-> FAULT_N_OE)
    else $error("fault pin idle while temperature fault live");
  shdn_gate_a: assert property (SHUTDOWN_TEMP_IN [*2] |=>
    PGA_SHDN && !EXC_EN && !COMP_EN && !FIELD_EN && !CURRENT_MODE
    && OW_CTRL == 6'h00)
    else $error("analog functions not gated in shutdown");
  shdn_release_a: assert property (
    !SHUTDOWN_TEMP_IN [*2] |=> !PGA_SHDN)
    else $error("amplifier still shut down after cool down");
  reset_off_a: assert property ($rose(RST_B) |->
    OW_CTRL == 6'h00 && !EXC_EN && !FIELD_EN && !FAULT_N_OE)
    else $error("outputs not off after reset");
  cover property (WB_ACK_O && WB_CYC_I);
  cover property ($rose(PGA_SHDN));
  cover property ($rose(FAULT_N_OE));
endmodule // afd_monitor

bind afd_top afd_monitor afd_monitor_inst (
  .CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .OVERTEMP_IN(OVERTEMP_IN),
  .SHUTDOWN_TEMP_IN(SHUTDOWN_TEMP_IN), .FAULT_N_O(FAULT_N_O),
  .FAULT_N_OE(FAULT_N_OE), .EXC_EN(EXC_EN), .COMP_EN(COMP_EN),
  .FIELD_EN(FIELD_EN), .CURRENT_MODE(CURRENT_MODE), .PGA_SHDN(PGA_SHDN),
  .OW_CTRL(OW_CTRL));

// ===== test/afd_host_model.sv
// host side: pulled-up fault wire and an outside party that may pull it
`timescale 1ns/1ps
module afd_host_model (
  // open-drain wire
  input  wire logic fault_n_o,
  input  wire logic fault_n_oe,
  input  wire logic ext_low,
  output wire logic fault_n_i
);
  // pull-up unless a party pulls low
  assign fault_n_i = (fault_n_oe ? fault_n_o : 1'b1) & !ext_low;
endmodule // afd_host_model

// ===== test/afd_top_bench.sv
// self-checking bench for the fault aggregator
`timescale 1ns/1ps
module afd_top_bench;
  import afd_pkg::*;
  localparam logic [7:0] A_SUM = {IDX_SUMMARY, 2'b00};
  localparam logic [7:0] A_DIS = {IDX_DISABLE, 2'b00};
  localparam logic [7:0] A_DET = {IDX_DETAIL, 2'b00};
  localparam logic [7:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_CNV = {IDX_CONV, 2'b00};
  logic        clk, rst_b, cyc, stb, we, ext_low, ack, fn_i, fn_o, fn_oe;
  logic        exc, comp, fld, cmode, pga;
  logic [7:0]  adr;
  logic [3:0]  sel, cev;
  logic [31:0] dat_w, dat_r, rd;
  logic [5:0]  ow;
  logic [9:0]  cmp;
  int          n_errors, check_count;

  afd_top afd_top_inst (
    .CLOCK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_ACK_O(ack), .OVERTEMP_IN(cmp[0]),
    .SHUTDOWN_TEMP_IN(cmp[1]), .POS_OVER_IN(cmp[2]), .NEG_OVER_IN(cmp[3]),
    .POS_UNDER_IN(cmp[4]), .NEG_UNDER_IN(cmp[5]), .FIELD_OC_IN(cmp[6]),
    .INPUT_OC_IN(cmp[7]), .EXC_COMPLY_IN(cmp[8]),
    .COMP_COMPLY_IN(cmp[9]), .CONV_DONE(cev[0]), .CAL_START(cev[1]),
    .CAL_END(cev[2]), .ADC_INT_ERR(cev[3]), .FAULT_N_I(fn_i),
    .FAULT_N_O(fn_o), .FAULT_N_OE(fn_oe), .EXC_EN(exc), .COMP_EN(comp),
    .FIELD_EN(fld), .CURRENT_MODE(cmode), .PGA_SHDN(pga), .OW_CTRL(ow));
  afd_host_model afd_host_model_inst (
    .fault_n_o(fn_o), .fault_n_oe(fn_oe), .ext_low(ext_low),
    .fault_n_i(fn_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat_w <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, e});
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    cev[b] <= 1'b1;
    @(posedge clk);
    cev[b] <= 1'b0;
  endtask
  task automatic t_reset;
    rdc(A_SUM, 16'h0000);
    rdc(A_DIS, DIS_RST);
    rdc(A_CTL, CTL_RST);
    rdc(A_CNV, 16'h0004);
    bus(1'b1, {IDX_NONE, 2'b00}, 16'hFFFF);
    rdc({IDX_NONE, 2'b00}, 16'h0000);
    bus(1'b1, A_DET, 16'hFFFF);
    rdc(A_DET, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_conv;
    bus(1'b1, A_CTL, 16'h1000);
    ext_low <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(A_CNV, 16'h0004);
    pulse(0);
    rdc(A_CNV, 16'h0006);
    ext_low <= 1'b0;
    rdc(A_CNV, 16'h0006);
    pulse(0);
    rdc(A_CNV, 16'h0004);
    bus(1'b1, A_CTL, 16'h2000);
    cev[3] <= 1'b1;
    pulse(0);
    repeat (3) @(posedge clk);
    chk({31'h0, fn_oe}, 32'h1);
    cev[3] <= 1'b0;
    pulse(0);
    repeat (3) @(posedge clk);
    chk({31'h0, fn_oe}, 32'h0);
    bus(1'b1, A_CTL, 16'h0000);
    ext_low <= 1'b1;
    pulse(0);
    rdc(A_CNV, 16'h0004);
    chk({31'h0, fn_oe}, 32'h0);
    ext_low <= 1'b0;
    pulse(1);
    rdc(A_CNV, 16'h0001);
    pulse(2);
    rdc(A_CNV, 16'h0004);
    $display("converter test done");
  endtask
  task automatic t_volt;
    for (int i = 0; i < 4; i++)
    begin
      cmp[2+i] <= 1'b1;
      rdc(A_DET, (16'h0100 << i) | 16'h0001);
      rdc(A_SUM, 16'h0001);
      chk({31'h0, fn_oe}, 32'h1);
      bus(1'b1, A_DIS, 16'h0100 << i);
      rdc(A_DET, 16'h0000);
      bus(1'b1, A_DIS, 16'h0000);
      cmp[2+i] <= 1'b0;
    end
    rdc(A_DET, 16'h0000);
    $display("voltage flag test done");
  endtask
  task automatic t_comply;
    bus(1'b1, A_CTL, 16'h0003);
    cmp[8] <= 1'b1;
    rdc(A_DET, 16'h0081);
    cmp[8] <= 1'b0;
    cmp[9] <= 1'b1;
    rdc(A_DET, 16'h0041);
    bus(1'b1, A_CTL, 16'h0007);
    repeat (3) @(posedge clk);
    chk({30'h0, exc, comp}, 32'h2);
    rdc(A_DET, 16'h0000);
    cmp[9] <= 1'b0;
    bus(1'b1, A_CTL, 16'h07E0);
    repeat (2) @(posedge clk);
    chk({26'h0, ow}, 32'h3F);
    $display("compliance test done");
  endtask
  task automatic t_mid_reset;
    bus(1'b1, A_DIS, 16'h0F00);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({26'h0, ow}, 32'h0);
    rst_b <= 1'b1;
    rdc(A_CTL, CTL_RST);
    rdc(A_DIS, DIS_RST);
    cmp[2] <= 1'b1;
    rdc(A_DET, 16'h0101);
    cmp[2] <= 1'b0;
    $display("mid-run reset test done");
  endtask
  task automatic t_temp;
    bus(1'b1, A_CTL, 16'h0019);
    cmp[2] <= 1'b1;
    cmp[5] <= 1'b1;
    rdc(A_DET, 16'h0901);
    cmp[2] <= 1'b0;
    cmp[5] <= 1'b0;
    cmp[0] <= 1'b1;
    repeat (3) @(posedge clk);
    cmp[0] <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(A_SUM, 16'h0004);
    rdc(A_SUM, 16'h0000);
    cmp[1] <= 1'b1;
    repeat (3) @(posedge clk);
    chk({28'h0, exc, fld, cmode, pga}, 32'h1);
    rdc(A_SUM, 16'h0009);
    cmp[1] <= 1'b0;
    repeat (3) @(posedge clk);
    chk({28'h0, exc, fld, cmode, pga}, 32'hE);
    rdc(A_SUM, 16'h0008);
    chk({31'h0, rd[0]}, 32'h0);
    rdc(A_SUM, 16'h0000);
    $display("temperature test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_b, cyc, stb, we, ext_low} = 5'h00;
    {adr, sel, cev, dat_w, cmp} = '0;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_conv();
    t_volt();
    t_comply();
    t_mid_reset();
    t_temp();
    tally_and_finish();
  end
endmodule // afd_top_bench
